// ===== pkg/speed_gain_pkg.sv
// constants, types and helpers shared by the speed loop gain logic
`default_nettype none
package speed_gain_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ            = 100;
  localparam int TICK_US            = 100;
  localparam int TICK_CYCLES_DFLT   = TICK_US * CLK_MHZ;
  localparam int HOLD_S             = 60;
  localparam int HOLD_TICKS_DFLT    = HOLD_S * 1000000 / TICK_US;
  localparam int ACCEL_S            = 30;
  localparam int ACCEL_TICKS_DFLT   = ACCEL_S * 1000000 / TICK_US;
  localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
  localparam int QUARTER_SHIFT      = 2;
  localparam logic [15:0] SPEED_TOL = 16'h0010;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_KP_A   = 8'h04;
  localparam logic [7:0] ADDR_KI_A   = 8'h08;
  localparam logic [7:0] ADDR_KD_A   = 8'h0C;
  localparam logic [7:0] ADDR_KP_B   = 8'h10;
  localparam logic [7:0] ADDR_KI_B   = 8'h14;
  localparam logic [7:0] ADDR_KD_B   = 8'h18;
  localparam logic [7:0] ADDR_BW     = 8'h1C;
  localparam logic [7:0] ADDR_COMPL  = 8'h20;
  localparam logic [7:0] ADDR_DAMP   = 8'h24;
  localparam logic [7:0] ADDR_INERT  = 8'h28;
  localparam logic [7:0] ADDR_REF    = 8'h2C;
  localparam logic [7:0] ADDR_RATED  = 8'h30;
  localparam logic [7:0] ADDR_RAMP   = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_TORQUE = 8'h3C;
  // ==========================================================
  // control and status fields
  localparam int CTRL_SEL_BIT    = 0;
  localparam int CTRL_EN_BIT     = 1;
  localparam int CTRL_METHOD_LSB = 4;
  localparam int CTRL_TUNE_BIT   = 8;
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_ATT_LSB    = 4;
  localparam int STAT_SEL_BIT    = 8;
  // ==========================================================
  // reset values
  localparam logic [15:0] KP_RST    = 16'h0100;
  localparam logic [15:0] KI_RST    = 16'h0010;
  localparam logic [15:0] KD_RST    = 16'h0000;
  localparam logic [15:0] BW_RST    = 16'h000A;
  localparam logic [15:0] COMPL_RST = 16'h0010;
  localparam logic [15:0] DAMP_RST  = 16'h0100;
  localparam logic [15:0] INERT_RST = 16'h0100;
  localparam logic [15:0] RATED_RST = 16'h1000;
  localparam logic [15:0] RAMP_RST  = 16'h0004;
  // ==========================================================
  // gain arithmetic
  localparam int GAIN_SHIFT          = 8;
  localparam int INERT_SHIFT         = 8;
  localparam int X16_SHIFT           = 4;
  localparam logic [15:0] DAMP_UNITY = 16'h0100;
  localparam logic [15:0] BW_LOW     = 16'h0005;
  localparam logic [15:0] BW_STD     = 16'h0019;
  localparam logic [15:0] BW_HIGH    = 16'h0064;
  localparam logic [15:0] COMPL_K    = 16'h0400;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    M_USER = 3'h0, M_BW = 3'h1, M_COMPL = 3'h2, M_KPX16 = 3'h3,
    M_LOW = 3'h4, M_STD = 3'h5, M_HIGH = 3'h6, M_SPARE = 3'h7
  } method_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'h0, T_ACCEL = 2'h1, T_HOLD = 2'h3, T_TRIP = 2'h2
  } tune_state_t;
  // ==========================================================
  // helpers
  function automatic logic [15:0] satU16(input logic [49:0] v);
    satU16 = (|v[49:16]) ? 16'hFFFF : v[15:0];
  endfunction
  function automatic logic signed [15:0] satS16(input logic signed [41:0] v);
    if (v > 42'sd32767) satS16 = 16'sh7FFF;
    else if (v < -42'sd32768) satS16 = -16'sh8000;
    else satS16 = v[15:0];
  endfunction
endpackage
`default_nettype wire

// ===== logic/gain_calc.sv
// automatic proportional and integral gain calculation
`default_nettype none
module gain_calc
  import speed_gain_pkg::*;
(
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst_n,
  // settings
  input  wire  method_t     method,
  input  wire  logic [15:0] bandwidth,
  input  wire  logic [15:0] compliance,
  input  wire  logic [15:0] damping,
  input  wire  logic [15:0] inertia,
  // results
  output logic [15:0]       kpCalc_q,
  output logic [15:0]       kiCalc_q,
  output logic              calcOn_q
);
  logic [15:0] effBw;
  logic [15:0] effDamp;
  logic        effOn;
  logic [49:0] kpRaw;
  logic [49:0] kiRaw;
  logic [15:0] complSafe;

  // zero angle would divide by zero; treat as the stiffest setting
  assign complSafe = (compliance == 16'h0000) ? 16'h0001 : compliance;

  // ==========================================================
  // source of bandwidth and damping
  always_comb begin
    effBw   = 16'h0000;
    effDamp = 16'h0000;
    effOn   = 1'b0;
    unique case (method)
      M_BW: begin
        effBw   = bandwidth;
        effDamp = damping;
        effOn   = 1'b1;
      end
      M_COMPL: begin
        effBw   = COMPL_K / complSafe;
        effDamp = damping;
        effOn   = 1'b1;
      end
      M_LOW: begin
        effBw   = BW_LOW;
        effDamp = DAMP_UNITY;
        effOn   = 1'b1;
      end
      M_STD: begin
        effBw   = BW_STD;
        effDamp = DAMP_UNITY;
        effOn   = 1'b1;
      end
      M_HIGH: begin
        effBw   = BW_HIGH;
        effDamp = DAMP_UNITY;
        effOn   = 1'b1;
      end
      default: begin
        effOn = 1'b0;
      end
    endcase
  end

  // kp ~ 2*zeta*w*J, ki ~ w*w*J
  assign kpRaw = ({34'h0, effBw} * {34'h0, effDamp} * {34'h0, inertia})
                 >> (GAIN_SHIFT + INERT_SHIFT - 1);
  assign kiRaw = ({34'h0, effBw} * {34'h0, effBw} * {34'h0, inertia}) >> INERT_SHIFT;

  // ==========================================================
  // recomputed every cycle so any setting change lands at the next update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kpCalc_q <= 16'h0000;
      kiCalc_q <= 16'h0000;
      calcOn_q <= 1'b0;
    end else begin
      kpCalc_q <= satU16(kpRaw);
      kiCalc_q <= satU16(kiRaw);
      calcOn_q <= effOn;
    end
  end
endmodule
`default_nettype wire

// ===== logic/speed_loop_gain_control.sv
// speed controller with two gain sets, gain set-up methods and inertia autotune
`default_nettype none
// Contract
// - PI on speed error forward; D term on speed feedback for damping.
// - Selector 0 picks gain set A, 1 picks gain set B.
// - Selector change accepted any time, enabled or not, and applied.
// - Zero integral gain leaves proportional only; torque needs speed error.
// - Integral accumulates error so steady torque needs no residual error.
// - Method 0 uses user written gains, no calculation.
// - Method 1 computes gains from bandwidth, damping and inertia.
// - Method 2 computes gains from compliance angle, damping and inertia.
// - Method 3 multiplies the selected proportional gain by sixteen.
// - Methods 4 to 6 overwrite set A gains for preset bandwidth, unity damping.
// - Preset bandwidths: 5 Hz, 25 Hz and 100 Hz for methods 4, 5, 6.
// - Inertia autotune fills the inertia setting used by calculations.
// - Autotune ramps to quarter rated speed, holds 60 s, trips on final failure.
module speed_loop_gain_control
  import speed_gain_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter int HOLD_TICKS  = HOLD_TICKS_DFLT,
  parameter int ACCEL_TICKS = ACCEL_TICKS_DFLT
) (
  // clock and reset
  input  wire  logic               clk,
  input  wire  logic               rst_n,
  // wishbone slave
  input  wire  logic               cyc_i,
  input  wire  logic               stb_i,
  input  wire  logic               we_i,
  input  wire  logic [7:0]         adr_i,
  input  wire  logic [3:0]         sel_i,
  input  wire  logic [31:0]        dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o,
  // speed feedback
  input  wire  logic signed [15:0] speedFb,
  // torque demand and autotune status
  output logic signed [15:0]       torqueDemand_q,
  output logic                     torqueValid_q,
  output logic                     tuneActive,
  output logic                     tuneTrip
);
  logic        sel_q;
  logic        en_q;
  method_t     method_q;
  logic [15:0] kpA_q;
  logic [15:0] kiA_q;
  logic [15:0] kdA_q;
  logic [15:0] kpB_q;
  logic [15:0] kiB_q;
  logic [15:0] kdB_q;
  logic [15:0] bw_q;
  logic [15:0] compl_q;
  logic [15:0] damp_q;
  logic [15:0] inert_q;
  logic [15:0] speedRef_q;
  logic [15:0] rated_q;
  logic [15:0] ramp_q;
  logic        ack_q;
  logic [31:0] rdData_q;
  logic        wrStb;
  logic        tuneStart;
  logic [15:0] kpCalc;
  logic [15:0] kiCalc;
  logic        calcOn;
  logic [31:0] tickCnt_q;
  logic        tick;
  tune_state_t tune_q;
  logic [31:0] tuneCnt_q;
  logic [1:0]  attempt_q;
  logic [15:0] rampRef_q;
  logic signed [39:0] torqueSum_q;
  logic [15:0] inertEst_q;
  logic [15:0] tuneTarget;
  logic signed [15:0] fbPrev_q;
  logic signed [39:0] integ_q;
  logic [15:0] kpSel;
  logic [15:0] kiSel;
  logic [15:0] kdSel;
  logic [15:0] kpUse;
  logic signed [16:0] refEff;
  logic signed [16:0] err;
  logic signed [16:0] dFb;
  logic signed [33:0] pTerm;
  logic signed [33:0] iStep;
  logic signed [33:0] dTerm;
  logic signed [41:0] integNext;
  logic signed [41:0] sumAll;
  logic [49:0] inertRaw;

  // applies wishbone byte lanes to a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16[7:0]  = s[0] ? d[7:0]  : old[7:0];
    merge16[15:8] = s[1] ? d[15:8] : old[15:8];
  endfunction

  // ==========================================================
  // wishbone slave: ack one cycle after the strobe, write at ack
  assign wrStb     = cyc_i & stb_i & we_i & ack_q;
  assign tuneStart = wrStb & (adr_i == ADDR_CTRL) & sel_i[1] & dat_i[CTRL_TUNE_BIT];
  assign ack_o     = ack_q;
  assign dat_o     = rdData_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i & stb_i & ~ack_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack_q) begin
      unique case (adr_i)
        ADDR_CTRL:   rdData_q <= {25'h0, method_q, 2'h0, en_q, sel_q};
        ADDR_KP_A:   rdData_q <= {16'h0, kpA_q};
        ADDR_KI_A:   rdData_q <= {16'h0, kiA_q};
        ADDR_KD_A:   rdData_q <= {16'h0, kdA_q};
        ADDR_KP_B:   rdData_q <= {16'h0, kpB_q};
        ADDR_KI_B:   rdData_q <= {16'h0, kiB_q};
        ADDR_KD_B:   rdData_q <= {16'h0, kdB_q};
        ADDR_BW:     rdData_q <= {16'h0, bw_q};
        ADDR_COMPL:  rdData_q <= {16'h0, compl_q};
        ADDR_DAMP:   rdData_q <= {16'h0, damp_q};
        ADDR_INERT:  rdData_q <= {16'h0, inert_q};
        ADDR_REF:    rdData_q <= {16'h0, speedRef_q};
        ADDR_RATED:  rdData_q <= {16'h0, rated_q};
        ADDR_RAMP:   rdData_q <= {16'h0, ramp_q};
        ADDR_STATUS: rdData_q <= {23'h0, sel_q, 2'h0, attempt_q, 2'h0, tune_q};
        ADDR_TORQUE: rdData_q <= {16'h0, torqueDemand_q};
        default:     rdData_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // control register; selector honoured whether enabled or not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q    <= 1'b0;
      en_q     <= 1'b0;
      method_q <= M_USER;
    end else if (wrStb && adr_i == ADDR_CTRL && sel_i[0]) begin
      sel_q    <= dat_i[CTRL_SEL_BIT];
      en_q     <= dat_i[CTRL_EN_BIT];
      method_q <= method_t'(dat_i[CTRL_METHOD_LSB +: 3]);
    end
  end

  // ==========================================================
  // gain set A; calculated methods overwrite it, hardware wins a clash
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kpA_q <= KP_RST;
      kiA_q <= KI_RST;
    end else if (calcOn) begin
      kpA_q <= kpCalc;
      kiA_q <= kiCalc;
    end else if (wrStb) begin
      if (adr_i == ADDR_KP_A) kpA_q <= merge16(kpA_q, dat_i, sel_i);
      if (adr_i == ADDR_KI_A) kiA_q <= merge16(kiA_q, dat_i, sel_i);
    end
  end

  // remaining plain settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kdA_q      <= KD_RST;
      kpB_q      <= KP_RST;
      kiB_q      <= KI_RST;
      kdB_q      <= KD_RST;
      bw_q       <= BW_RST;
      compl_q    <= COMPL_RST;
      damp_q     <= DAMP_RST;
      speedRef_q <= 16'h0000;
      rated_q    <= RATED_RST;
      ramp_q     <= RAMP_RST;
    end else if (wrStb) begin
      unique case (adr_i)
        ADDR_KD_A:  kdA_q      <= merge16(kdA_q, dat_i, sel_i);
        ADDR_KP_B:  kpB_q      <= merge16(kpB_q, dat_i, sel_i);
        ADDR_KI_B:  kiB_q      <= merge16(kiB_q, dat_i, sel_i);
        ADDR_KD_B:  kdB_q      <= merge16(kdB_q, dat_i, sel_i);
        ADDR_BW:    bw_q       <= merge16(bw_q, dat_i, sel_i);
        ADDR_COMPL: compl_q    <= merge16(compl_q, dat_i, sel_i);
        ADDR_DAMP:  damp_q     <= merge16(damp_q, dat_i, sel_i);
        ADDR_REF:   speedRef_q <= merge16(speedRef_q, dat_i, sel_i);
        ADDR_RATED: rated_q    <= merge16(rated_q, dat_i, sel_i);
        ADDR_RAMP:  ramp_q     <= merge16(ramp_q, dat_i, sel_i);
        default:    ;
      endcase
    end
  end

  // inertia: software write, or the autotune result at completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inert_q <= INERT_RST;
    end else if (tick && tune_q == T_HOLD && tuneCnt_q == 32'(HOLD_TICKS - 1)) begin
      inert_q <= inertEst_q;
    end else if (wrStb && adr_i == ADDR_INERT) begin
      inert_q <= merge16(inert_q, dat_i, sel_i);
    end
  end

  gain_calc u_calc (
    .clk        (clk),
    .rst_n      (rst_n),
    .method     (method_q),
    .bandwidth  (bw_q),
    .compliance (compl_q),
    .damping    (damp_q),
    .inertia    (inert_q),
    .kpCalc_q   (kpCalc),
    .kiCalc_q   (kiCalc),
    .calcOn_q   (calcOn)
  );

  // ==========================================================
  // control update tick
  assign tick = (tickCnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 32'h0000_0000;
    end else begin
      tickCnt_q <= tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
    end
  end

  // ==========================================================
  // inertia autotune sequencer
  assign tuneTarget = rated_q >> QUARTER_SHIFT;
  assign tuneActive = (tune_q == T_ACCEL) | (tune_q == T_HOLD);
  assign tuneTrip   = (tune_q == T_TRIP);
  assign inertRaw   = 50'(torqueSum_q[39] ? 40'h0 : torqueSum_q) /
                      50'((tuneTarget == 16'h0000) ? 16'h0001 : tuneTarget);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_q      <= T_IDLE;
      tuneCnt_q   <= 32'h0000_0000;
      attempt_q   <= 2'h0;
      rampRef_q   <= 16'h0000;
      torqueSum_q <= 40'sh0;
      inertEst_q  <= 16'h0000;
    end else begin
      unique case (tune_q)
        T_IDLE, T_TRIP: begin
          if (tuneStart) begin
            tune_q      <= T_ACCEL;
            tuneCnt_q   <= 32'h0000_0000;
            attempt_q   <= 2'h0;
            rampRef_q   <= 16'h0000;
            torqueSum_q <= 40'sh0;
          end
        end
        T_ACCEL: if (tick) begin
          // ramp at the selected rate toward a quarter of rated speed
          rampRef_q   <= (rampRef_q + ramp_q >= tuneTarget) ? tuneTarget : rampRef_q + ramp_q;
          torqueSum_q <= torqueSum_q + 40'(torqueDemand_q);
          tuneCnt_q   <= tuneCnt_q + 32'h0000_0001;
          if (speedFb >= $signed(tuneTarget - SPEED_TOL)) begin
            tune_q     <= T_HOLD;
            tuneCnt_q  <= 32'h0000_0000;
            inertEst_q <= satU16(inertRaw);
          end else if (tuneCnt_q == 32'(ACCEL_TICKS - 1)) begin
            if (attempt_q == MAX_ATTEMPTS - 2'h1) begin
              tune_q <= T_TRIP;
            end else begin
              attempt_q   <= attempt_q + 2'h1;
              tuneCnt_q   <= 32'h0000_0000;
              rampRef_q   <= 16'h0000;
              torqueSum_q <= 40'sh0;
            end
          end
        end
        T_HOLD: if (tick) begin
          tuneCnt_q <= tuneCnt_q + 32'h0000_0001;
          if (tuneCnt_q == 32'(HOLD_TICKS - 1)) tune_q <= T_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // speed controller datapath
  assign kpSel  = sel_q ? kpB_q : kpA_q;
  assign kiSel  = sel_q ? kiB_q : kiA_q;
  assign kdSel  = sel_q ? kdB_q : kdA_q;
  assign kpUse  = (method_q == M_KPX16) ? satU16({34'h0, kpSel} << X16_SHIFT) : kpSel;
  assign refEff = tuneActive ? $signed({1'b0, rampRef_q}) : 17'(signed'(speedRef_q));
  assign err    = refEff - 17'(speedFb);
  assign dFb    = 17'(speedFb) - 17'(fbPrev_q);
  assign pTerm  = err * $signed({1'b0, kpUse});
  assign iStep  = err * $signed({1'b0, kiSel});
  assign dTerm  = dFb * $signed({1'b0, kdSel});
  assign integNext = (kiSel == 16'h0000) ? 42'sh0 : 42'(integ_q) + 42'(iStep);
  // derivative acts on feedback only, so a reference step gives no kick
  assign sumAll = (42'(pTerm) + integNext - 42'(dTerm)) >>> GAIN_SHIFT;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_q        <= 40'sh0;
      fbPrev_q       <= 16'sh0;
      torqueDemand_q <= 16'sh0;
      torqueValid_q  <= 1'b0;
    end else begin
      torqueValid_q <= tick & (en_q | tuneActive);
      if (tick) begin
        fbPrev_q <= speedFb;
        if (en_q || tuneActive) begin
          // integrator clamped to a 40-bit range to stop wind-up overflow
          integ_q <= (integNext > 42'sh7F_FFFF_FFFF) ? 40'sh7F_FFFF_FFFF :
                     (integNext < -42'sh80_0000_0000) ? -40'sh80_0000_0000 :
                     integNext[39:0];
          torqueDemand_q <= satS16(sumAll);
        end else begin
          integ_q        <= 40'sh0;
          torqueDemand_q <= 16'sh0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/speed_fb_model.sv
// shaft speed model feeding the controller's speed input
`default_nettype none
module speed_fb_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // shaft speed chosen by the bench
  input  wire logic signed [15:0] fbSet,
  output logic signed [15:0]      speedFb
);
  // ==========================================
  // locked load: speed is imposed, torque cannot move it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) speedFb <= 16'sh0000;
    else speedFb <= fbSet;
  end
endmodule
`default_nettype wire

// ===== test/speed_loop_gain_chk.sv
// port checker for the speed loop gain controller
`default_nettype none
module speed_loop_gain_chk
  import speed_gain_pkg::*;
#(
  parameter int TICK_CYCLES = 10,
  parameter int HOLD_TICKS  = 20,
  parameter int ACCEL_TICKS = 10
) (
  // clock, reset and bus
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               cyc_i,
  input wire logic               stb_i,
  input wire logic               we_i,
  input wire logic [7:0]         adr_i,
  input wire logic [3:0]         sel_i,
  input wire logic [31:0]        dat_i,
  input wire logic [31:0]        dat_o,
  input wire logic               ack_o,
  // loop and autotune
  input wire logic signed [15:0] speedFb,
  input wire logic signed [15:0] torqueDemand_q,
  input wire logic               torqueValid_q,
  input wire logic               tuneActive,
  input wire logic               tuneTrip
);
  // ==========================================
  // shadow of the enable bit, taken at the ack edge
  logic enCopy_q;
  logic wrReq;
  logic tuneReq;
  assign wrReq = cyc_i && stb_i && we_i;
  assign tuneReq = wrReq && adr_i == ADDR_CTRL && dat_i[CTRL_TUNE_BIT];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) enCopy_q <= 1'b0;
    else if (wrReq && ack_o && adr_i == ADDR_CTRL && sel_i[0]) enCopy_q <= dat_i[CTRL_EN_BIT];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // bus and loop relations
  property p_ack_take; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not acked next cycle");
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_upper; ack_o && !we_i |-> dat_o[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmapped; ack_o && !we_i && adr_i > ADDR_TORQUE |-> dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_gap; torqueValid_q |=> !torqueValid_q [*8]; endproperty
  a_gap: assert property (p_gap) else $error("updates closer than a tick");
  property p_tick;
    $changed(torqueDemand_q) && enCopy_q && !tuneActive && !$past(tuneActive)
      && !wrReq && !$past(wrReq) |-> torqueValid_q;
  endproperty
  a_tick: assert property (p_tick) else $error("torque moved off a tick");
  property p_trip_hold; tuneTrip && !tuneReq && !$past(tuneReq) |=> tuneTrip; endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip cleared early");
  property p_trip_src; $rose(tuneTrip) |-> $past(tuneActive); endproperty
  a_trip_src: assert property (p_trip_src) else $error("trip without test");
endmodule
bind speed_loop_gain_control speed_loop_gain_chk #(.TICK_CYCLES(TICK_CYCLES),
  .HOLD_TICKS(HOLD_TICKS), .ACCEL_TICKS(ACCEL_TICKS)) u_chk (.clk(clk), .rst_n(rst_n),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .speedFb(speedFb), .torqueDemand_q(torqueDemand_q),
  .torqueValid_q(torqueValid_q), .tuneActive(tuneActive), .tuneTrip(tuneTrip));
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the speed loop gain controller
`default_nettype none
module testbench
  import speed_gain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;
  localparam int HT = 20;
  localparam int AT = 10;
  logic               clk, rst_n, cyc, stb, we, ack, tValid, tuneActive, tuneTrip;
  logic        [7:0]  adr;
  logic        [3:0]  sel;
  logic        [31:0] wdat, dat, r;
  logic signed [15:0] speedFb, fbSet, torque;
  logic        [15:0] t1, t2;
  int                 nErrors, checkCount, n, i;
  logic        [15:0] rVal [17] = '{16'h0000, KP_RST, KI_RST, KD_RST, KP_RST, KI_RST, KD_RST,
    BW_RST, COMPL_RST, DAMP_RST, INERT_RST, 16'h0000, RATED_RST, RAMP_RST, 16'h0000,
    16'h0000, 16'h0000};
  logic        [2:0]  mList [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic        [15:0] kpE [5] = '{16'h0014, 16'h0080, 16'h000A, 16'h0032, 16'h00C8};
  logic        [15:0] kiE [5] = '{16'h0064, 16'h1000, 16'h0019, 16'h0271, 16'h2710};
  // short counts keep the run brief
  speed_loop_gain_control #(.TICK_CYCLES(TK), .HOLD_TICKS(HT), .ACCEL_TICKS(AT))
    u_speed_loop_gain_control (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat), .ack_o(ack), .speedFb(speedFb),
    .torqueDemand_q(torque), .torqueValid_q(tValid), .tuneActive(tuneActive),
    .tuneTrip(tuneTrip));
  speed_fb_model u_speed_fb_model (.clk(clk), .rst_n(rst_n), .fbSet(fbSet), .speedFb(speedFb));
  // ==========================================
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic fail();
    nErrors++;
    summarize();
  endtask
  // ==========================================
  // wishbone classic master
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 20) fail();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    xfer(1'b1, a, {16'h0, d}, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0, r);
    check(r, {16'h0, e});
  endtask
  // ==========================================
  // loop observation
  task automatic getT(input int k, output logic [15:0] t);
    int c;
    int m;
    m = 0;
    for (c = 0; c < 40 * k && m < k; c++) begin
      @(negedge clk);
      if (tValid === 1'b1) m++;
    end
    if (m < k) fail();
    t = torque;
  endtask
  task automatic tq(input logic [15:0] e);
    logic [15:0] t;
    getT(2, t);
    check({16'h0, t}, {16'h0, e});
  endtask
  task automatic waitTune(output int cnt);
    int k;
    cnt = 0;
    for (k = 0; k < 2000 && !(k > 2 && tuneActive === 1'b0); k++) begin
      @(negedge clk);
      if (tuneActive === 1'b1) cnt++;
    end
    if (k == 2000) fail();
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h3;
    wdat = 32'h0;
    fbSet = 16'sh0000;
    nErrors = 0;
    checkCount = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 17; i++) if (i != 11) rd(8'(i * 4), rVal[i]);
    for (i = 0; i < 5; i++) begin
      wr(ADDR_CTRL, {9'h0, mList[i], 4'h0});
      repeat (3) @(posedge clk);
      rd(ADDR_KP_A, kpE[i]);
      rd(ADDR_KI_A, kiE[i]);
    end
    wr(ADDR_CTRL, 16'h0010);
    wr(ADDR_KP_A, 16'h1234);
    rd(ADDR_KP_A, 16'h0014);
    wr(ADDR_BW, 16'h0014);
    repeat (3) @(posedge clk);
    rd(ADDR_KP_A, 16'h0028);
    rd(ADDR_KI_A, 16'h0190);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_KP_A, 16'h0100);
    rd(ADDR_KP_A, 16'h0100);
    wr(ADDR_KI_A, 16'h0000);
    wr(ADDR_KP_B, 16'h0200);
    wr(ADDR_KI_B, 16'h0000);
    wr(ADDR_REF, 16'h0020);
    wr(ADDR_CTRL, 16'h0002);
    tq(16'h0020);
    fbSet <= 16'sh0020;
    tq(16'h0000);
    fbSet <= 16'sh0000;
    // selector flipped while running
    wr(ADDR_CTRL, 16'h0003);
    tq(16'h0040);
    rd(ADDR_STATUS, 16'h0100);
    wr(ADDR_CTRL, 16'h0033);
    tq(16'h0400);
    wr(ADDR_CTRL, 16'h0032);
    tq(16'h0200);
    wr(ADDR_CTRL, 16'h0002);
    wr(ADDR_KP_A, 16'h0000);
    wr(ADDR_KI_A, 16'h0100);
    fbSet <= 16'sh0010;
    getT(2, t1);
    getT(1, t2);
    check({16'h0, t2 - t1}, 32'h10);
    fbSet <= 16'sh0020;
    getT(2, t1);
    getT(1, t2);
    check({16'h0, t2}, {16'h0, t1});
    check({31'h0, t1 != 16'h0}, 32'h1);
    wr(ADDR_CTRL, 16'h0000);
    repeat (3 * TK) @(posedge clk);
    rd(ADDR_TORQUE, 16'h0000);
    // stalled shaft: every attempt fails
    wr(ADDR_RAMP, 16'h0100);
    fbSet <= 16'sh0000;
    wr(ADDR_CTRL, 16'h0100);
    waitTune(n);
    check({31'h0, n >= (3 * AT - 1) * TK}, 32'h1);
    check({31'h0, tuneTrip}, 32'h1);
    rd(ADDR_STATUS, {10'h0, MAX_ATTEMPTS - 2'h1, 2'h0, T_TRIP});
    fbSet <= 16'sh03F8;
    wr(ADDR_CTRL, 16'h0100);
    waitTune(n);
    check({31'h0, n >= HT * TK && n <= (AT + HT + 2) * TK}, 32'h1);
    check({31'h0, tuneTrip}, 32'h0);
    rd(ADDR_STATUS, {14'h0, T_IDLE});
    rd(ADDR_INERT, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
